/* File: hw/rcv_pkg.sv */
// Package for the reset-cause tracker: register map, flag positions, vector layout
package rcv_pkg;
  // AXI4-Lite register byte addresses
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_EVENT = 8'h04;
  localparam logic [7:0] ADDR_REMAP_BASE = 8'h10;
  localparam int REMAP_COUNT = 4;
  localparam logic [7:0] ADDR_VECTOR = 8'h08;
  localparam logic [7:0] ADDR_VECTOR_RES = 8'h0c;

  // Reset-cause flag positions
  localparam int BIT_POWERON = 0;
  localparam int BIT_BROWNOUT = 1;
  localparam int BIT_IDLE = 2;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_WATCHDOG = 4;
  localparam int BIT_SOFTWARE = 6;
  localparam int BIT_EXTERNAL = 7;
  localparam int BIT_MISMATCH = 9;
  localparam int BIT_ILLEGAL = 14;
  localparam int BIT_TRAP = 15;
  localparam logic [15:0] CAUSE_MASK = 16'hc2df;
  localparam logic [15:0] CAUSE_RESET = 16'h0000;

  // Vector table layout
  localparam logic [23:0] VEC_RESET_GOTO = 24'h000000;
  localparam logic [23:0] VEC_RESET_ADDR = 24'h000002;
  localparam logic [23:0] VEC_TRAP_BASE = 24'h000004;
  localparam logic [23:0] VEC_IRQ_BASE = 24'h000014;
  localparam logic [23:0] VEC_IRQ_LAST = 24'h0000fe;
  localparam logic [23:0] VEC_ALT_OFFSET = 24'h000100;
  localparam logic [23:0] VEC_CODE_START = 24'h000200;
  localparam logic [6:0] IRQ_LAST = 7'd117;
  localparam logic [7:0] ILLEGAL_OPCODE = 8'h3f;

  localparam int NUM_WREGS = 16;
  localparam logic [3:0] STACK_WREG = 4'd15;

  // Trap vector kinds in table order after the reserved word
  typedef enum logic [2:0] {
    TRAP_OSC_FAIL, TRAP_ADDR_ERR, TRAP_STACK_ERR, TRAP_MATH_ERR, TRAP_DMA_ERR
  } rcv_trap_e;

  // Core-side events, one cycle pulses
  typedef struct packed {
    logic trapConflict;
    logic resetInstr;
    logic watchdogTimeout;
    logic watchdogClear;
    logic powerSaveSleep;
    logic powerSaveIdle;
  } rcv_event_s;

  // Instruction execute view
  typedef struct packed {
    logic valid;
    logic [23:0] word;
    logic usesPointer;
    logic [3:0] pointerReg;
    logic wregWrite;
    logic [3:0] wregIdx;
  } rcv_exec_s;

  // Program-counter reload view
  typedef struct packed {
    logic flowChange;
    logic vectorChange;
    logic [23:0] target;
  } rcv_flow_s;
endpackage

/* File: hw/rcv_reset_cause.sv */
// Reset-cause tracker with shadow compare, illegal-condition detect and vector map
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Contract
// - Shadow remap registers; mismatch forces device reset
// - Mismatch sets bit 9; power-on, brown-out clear
// - Illegal conditions set bit 14; power-on, brown-out clear
// - Executing illegal opcode resets device
// - Uninitialized pointer register use resets device
// - Reset clears W0-W14, marks them uninitialized
// - Restricted target of flow change resets
// - Branch, call, return reloads are flow changes
// - Vector loads are vector flow changes
// - Trap conflict sets bit 15; power-on, brown-out clear
// - Pin reset sets bit 7; only power-on clears
// - Reset instruction sets bit 6; power-on, brown-out clear
// - Watchdog sets bit 4; several clears
// - Sleep sets bit 3, idle bit 2
// - Power-on, brown-out set bit 1; power-on bit 0
// - Software can set or clear every flag
// - Reset jump at 0, target at 2
// - Trap vectors follow reserved word in order
// - 118 primary vectors, lower number higher priority
// - Alternate table offset 0x100, code at 0x200
module rcv_reset_cause
  import rcv_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic powerOnReset,
  input wire logic brownoutReset,
  input wire logic masterClearPin,
  input wire rcv_event_s coreEvent,
  input wire rcv_exec_s exec,
  input wire rcv_flow_s flow,
  input wire logic [23:0] restrictLow,
  input wire logic [23:0] restrictHigh,
  input wire logic protectEnable,
  input wire logic shadowUpset,
  input wire logic altTableSelect,
  input wire logic [6:0] irqNumber,
  input wire logic [2:0] trapKind,
  output logic [23:0] irqVectorAddr,
  output logic [23:0] trapVectorAddr,
  output logic deviceReset,
  output logic [NUM_WREGS-1:0] wregValid,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [15:0] causeReg;
  logic [15:0] remapReg [REMAP_COUNT];
  logic [15:0] remapShadow [REMAP_COUNT];
  logic [REMAP_COUNT-1:0] remapDiff;
  logic [7:0] awAddr;
  logic awHeld;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wHeld;
  logic wrFire;
  logic [15:0] hwSet;
  logic [15:0] hwClear;
  logic [15:0] swMask;
  logic [15:0] swValue;
  logic illegalOpcode;
  logic uninitPointer;
  logic securityHit;
  logic mismatchHit;
  logic [23:0] irqBase;
  logic [15:0] wrHalf;

  // Write channel: address and data may arrive in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  assign wrHalf = {wStrb[1] ? wData[15:8] : 8'h00, wStrb[0] ? wData[7:0] : 8'h00};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (wrFire) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wHeld <= 1'b0;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr == ADDR_CAUSE || awAddr == ADDR_EVENT ||
                      (awAddr >= ADDR_REMAP_BASE &&
                       awAddr < ADDR_REMAP_BASE + 8'(4 * REMAP_COUNT))) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software access to the cause flags, byte-lane masked
  always_comb begin
    swMask = 16'h0000;
    swValue = wrHalf;
    if (wrFire && awAddr == ADDR_CAUSE) begin
      swMask = {{8{wStrb[1]}}, {8{wStrb[0]}}} & CAUSE_MASK;
    end
  end

  // Pin-remap registers and their hardware shadows
  generate
    for (genvar i = 0; i < REMAP_COUNT; i++) begin : g_remap
      logic hit;
      assign hit = wrFire && awAddr == ADDR_REMAP_BASE + 8'(4 * i);
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          remapReg[i] <= 16'h0000;
          remapShadow[i] <= 16'h0000;
        end else if (hit) begin
          remapReg[i] <= wrHalf;
          remapShadow[i] <= wrHalf;
        end else if (shadowUpset && i == 0) begin
          // Models a cell upset: live copy flips, shadow stays
          remapReg[i] <= ~remapReg[i];
        end
      end
      assign remapDiff[i] = remapReg[i] != remapShadow[i];
    end
  endgenerate

  assign mismatchHit = |remapDiff;
  assign illegalOpcode = exec.valid && exec.word[23:16] == ILLEGAL_OPCODE;
  assign uninitPointer = exec.valid && exec.usesPointer &&
                         !wregValid[exec.pointerReg];
  assign securityHit = protectEnable && (flow.flowChange || flow.vectorChange) &&
                       flow.target >= restrictLow && flow.target <= restrictHigh;

  // Any illegal condition or mismatch resets the core
  assign deviceReset = mismatchHit || illegalOpcode || uninitPointer || securityHit ||
                       masterClearPin || coreEvent.resetInstr || coreEvent.watchdogTimeout ||
                       coreEvent.trapConflict || powerOnReset || brownoutReset;

  // Working-register initialized map, stack pointer always valid
  always_ff @(posedge clk) begin
    if (sys_rst || deviceReset) begin
      wregValid <= NUM_WREGS'(1) << STACK_WREG;
    end else if (exec.valid && exec.wregWrite) begin
      wregValid[exec.wregIdx] <= 1'b1;
    end
  end

  always_comb begin
    hwSet = 16'h0000;
    hwClear = 16'h0000;
    hwSet[BIT_TRAP] = coreEvent.trapConflict;
    hwSet[BIT_ILLEGAL] = illegalOpcode || uninitPointer || securityHit;
    hwSet[BIT_MISMATCH] = mismatchHit;
    hwSet[BIT_EXTERNAL] = masterClearPin;
    hwSet[BIT_SOFTWARE] = coreEvent.resetInstr;
    hwSet[BIT_WATCHDOG] = coreEvent.watchdogTimeout;
    hwSet[BIT_SLEEP] = coreEvent.powerSaveSleep;
    hwSet[BIT_IDLE] = coreEvent.powerSaveIdle;
    hwSet[BIT_BROWNOUT] = powerOnReset || brownoutReset;
    hwSet[BIT_POWERON] = powerOnReset;
    if (powerOnReset || brownoutReset) begin
      hwClear = CAUSE_MASK & ~16'(1 << BIT_EXTERNAL);
      hwClear[BIT_BROWNOUT] = 1'b0;
      hwClear[BIT_POWERON] = 1'b0;
    end
    if (powerOnReset) begin
      hwClear[BIT_EXTERNAL] = 1'b1;
    end
    if (coreEvent.powerSaveSleep || coreEvent.powerSaveIdle || coreEvent.watchdogClear) begin
      hwClear[BIT_WATCHDOG] = 1'b1;
    end
  end

  // Hardware set wins over software write and hardware clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      causeReg <= CAUSE_RESET;
    end else begin
      causeReg <= (((causeReg & ~swMask) | (swValue & swMask)) & ~hwClear) | hwSet;
    end
  end

  // Vector address generation for the core's fetch unit
  assign irqBase = altTableSelect ? VEC_IRQ_BASE + VEC_ALT_OFFSET : VEC_IRQ_BASE;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqVectorAddr <= VEC_RESET_GOTO;
      trapVectorAddr <= VEC_TRAP_BASE;
    end else begin
      irqVectorAddr <= (irqNumber > IRQ_LAST) ? VEC_CODE_START :
                       irqBase + {16'h0000, irqNumber, 1'b0};
      trapVectorAddr <= (altTableSelect ? VEC_ALT_OFFSET : 24'h000000) +
                        VEC_TRAP_BASE + {20'h00000, trapKind + 3'd1, 1'b0};
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        ADDR_CAUSE: s_axi_rdata <= {16'h0000, causeReg};
        ADDR_EVENT: s_axi_rdata <= {16'h0000, wregValid};
        ADDR_VECTOR: s_axi_rdata <= {8'h00, irqVectorAddr};
        ADDR_VECTOR_RES: s_axi_rdata <= {8'h00, VEC_RESET_ADDR};
        ADDR_REMAP_BASE: s_axi_rdata <= {16'h0000, remapReg[0]};
        ADDR_REMAP_BASE + 8'h04: s_axi_rdata <= {16'h0000, remapReg[1]};
        ADDR_REMAP_BASE + 8'h08: s_axi_rdata <= {16'h0000, remapReg[2]};
        ADDR_REMAP_BASE + 8'h0c: s_axi_rdata <= {16'h0000, remapReg[3]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* File: testbench/rcv_reset_cause_monitor.sv */
// Assertion checker on the reset-cause tracker ports
`timescale 1ns/1ns
module rcv_reset_cause_chk
  import rcv_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic masterClearPin,
  input wire rcv_exec_s exec,
  input wire rcv_flow_s flow,
  input wire logic [23:0] restrictLow,
  input wire logic [23:0] restrictHigh,
  input wire logic protectEnable,
  input wire logic altTableSelect,
  input wire logic [6:0] irqNumber,
  input wire logic [2:0] trapKind,
  input wire logic [23:0] irqVectorAddr,
  input wire logic [23:0] trapVectorAddr,
  input wire logic deviceReset,
  input wire logic [NUM_WREGS-1:0] wregValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic hot;
  assign hot = protectEnable && flow.target >= restrictLow && flow.target <= restrictHigh;
  chk_pin_reset: assert property (masterClearPin |-> deviceReset)
    else $error("pin reset not issued");
  chk_bad_opcode: assert property (exec.valid && exec.word[23:16] == ILLEGAL_OPCODE
    |-> deviceReset) else $error("illegal opcode ran");
  chk_cold_pointer: assert property (exec.valid && exec.usesPointer
    && !wregValid[exec.pointerReg] |-> deviceReset) else $error("cold pointer ran");
  chk_flow_guard: assert property (flow.flowChange && hot |-> deviceReset)
    else $error("flow change not guarded");
  chk_vector_guard: assert property (flow.vectorChange && hot |-> deviceReset)
    else $error("vector change not guarded");
  chk_wreg_clear: assert property (deviceReset |=> wregValid == 16'h8000)
    else $error("working registers not cleared");
  // Vector outputs are registered, so each is checked one edge after its inputs
  chk_irq_vector: assert property (!sys_rst && irqNumber <= IRQ_LAST
    |=> irqVectorAddr == VEC_IRQ_BASE + 24'($past(irqNumber)) * 2 +
    ($past(altTableSelect) ? VEC_ALT_OFFSET : 24'h0))
    else $error("interrupt vector wrong");
  chk_trap_vector: assert property (!sys_rst && trapKind <= 3'd4
    |=> trapVectorAddr == VEC_TRAP_BASE + 24'($past(trapKind)) * 2 + 24'h2 +
    ($past(altTableSelect) ? VEC_ALT_OFFSET : 24'h0))
    else $error("trap vector wrong");
  cover property (exec.valid && exec.usesPointer && deviceReset);
  cover property (flow.vectorChange && hot);
  cover property (irqNumber == IRQ_LAST && altTableSelect);
endmodule

bind rcv_reset_cause rcv_reset_cause_chk rcv_reset_cause_chk_inst (.clk, .sys_rst,
  .masterClearPin, .exec, .flow, .restrictLow, .restrictHigh, .protectEnable,
  .altTableSelect, .irqNumber, .trapKind, .irqVectorAddr, .trapVectorAddr,
  .deviceReset, .wregValid);

/* File: testbench/rcv_reset_cause_bench.sv */
// Self-checking bench for the reset-cause tracker
`timescale 1ns/1ns
module rcv_reset_cause_bench
  import rcv_pkg::*;
  ;
  logic clk = 0, sys_rst = 1, por = 0, brownRst = 0, pinRst = 0, upset = 0, alt = 0;
  // Ready lines stay high; each answer is taken at the edge it is seen
  logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1, guard = 1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [23:0] tgt = '0;
  logic [6:0] irq = '0;
  logic [2:0] trap = '0;
  rcv_event_s ev = '0;
  rcv_exec_s ex = '0;
  rcv_flow_s fl = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [33:0] expQ[$];
  int miscompares = 0, num_checks = 0;
  int bits[8] = '{7, 15, 6, 4, 3, 2, 14, 9};

  always #25 clk = ~clk;

  rcv_reset_cause rcv_reset_cause_inst (.clk, .sys_rst, .powerOnReset(por),
    .brownoutReset(brownRst), .masterClearPin(pinRst), .coreEvent(ev), .exec(ex), .flow(fl),
    .restrictLow(24'h000400), .restrictHigh(24'h0004ff), .protectEnable(guard),
    .shadowUpset(upset), .altTableSelect(alt), .irqNumber(irq), .trapKind(trap),
    .irqVectorAddr(), .trapVectorAddr(), .deviceReset(), .wregValid(),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic check(input string n, input logic [33:0] e, input logic [33:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // Writes and reads never overlap, so one queue keeps the order
  always @(posedge clk) begin
    if (bvalid && bready) check("write response", expQ.pop_front(), {bresp, 32'h0});
    if (rvalid && rready) check("read data", expQ.pop_front(), {rresp, rdata});
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    expQ.push_back(34'h0);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (aw || w) begin
      @(posedge clk);
      if (awready) aw = 0;
      if (wready) w = 0;
      awvalid <= aw;
      wvalid <= w;
    end
    do @(posedge clk); while (!bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'd0);
    expQ.push_back({r, d});
    araddr <= a;
    arvalid <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
  endtask

  // One-cycle stimulus pulse of the chosen event kind
  task automatic hit(input int k);
    case (k)
      0: pinRst <= 1;
      1: ev.trapConflict <= 1;
      2: ev.resetInstr <= 1;
      3: ev.watchdogTimeout <= 1;
      4: ev.powerSaveSleep <= 1;
      5: ev.powerSaveIdle <= 1;
      6: ex <= {1'b1, 8'h3f, 16'($urandom), 10'h0};
      7: upset <= 1;
      8: ev.watchdogClear <= 1;
      9: brownRst <= 1;
      10: por <= 1;
      11: fl <= {2'b10, tgt};
      12: fl <= {2'b01, tgt};
      13: ex <= {1'b1, 24'h0, 1'b1, 4'd3, 5'h0};
      default: ex <= {1'b1, 24'h0, 5'h0, 1'b1, 4'd3};
    endcase
    @(posedge clk);
    {pinRst, brownRst, por, upset} <= '0;
    ev <= '0;
    ex <= '0;
    fl <= '0;
    // Idle edge, so a following pulse never reassigns in this step
    @(posedge clk);
  endtask

  task automatic summarize;
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hf173045d));
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    rd(ADDR_CAUSE, 0);
    rd(ADDR_EVENT, 32'h8000);
    rd(ADDR_VECTOR_RES, 32'h2);
    rd(8'h40, 0, 2'd2);
    for (int k = 0; k < 8; k++) begin
      hit(k);
      if (k == 7) wr(ADDR_REMAP_BASE, 0);
      rd(ADDR_CAUSE, 32'h1 << bits[k]);
      wr(ADDR_CAUSE, 0);
      rd(ADDR_CAUSE, 0);
    end
    hit(3);
    hit(4);
    rd(ADDR_CAUSE, 32'h8);
    hit(3);
    hit(8);
    rd(ADDR_CAUSE, 32'h8);
    wr(ADDR_CAUSE, 32'hffff);
    rd(ADDR_CAUSE, 32'(CAUSE_MASK));
    hit(9);
    rd(ADDR_CAUSE, 32'h83);
    hit(10);
    rd(ADDR_CAUSE, 32'h3);
    wr(ADDR_CAUSE, 0);
    hit(13);
    rd(ADDR_CAUSE, 32'h4000);
    hit(14);
    rd(ADDR_EVENT, 32'h8008);
    wr(ADDR_CAUSE, 0);
    // A written pointer register is initialized and must not reset
    hit(13);
    rd(ADDR_CAUSE, 0);
    hit(0);
    rd(ADDR_EVENT, 32'h8000);
    for (int k = 11; k < 15; k++) begin
      wr(ADDR_CAUSE, 0);
      tgt = (k == 11) ? 24'h400 + 24'($urandom_range(255)) : (k == 12) ? 24'h4ff : 24'h500;
      if (k == 14) tgt = 24'h400;
      // Last pass has protection off, so an in-window target is harmless
      guard <= (k != 14);
      hit(k > 12 ? 11 : k);
      rd(ADDR_CAUSE, k > 12 ? 32'h0 : 32'h4000);
    end
    for (int i = 0; i < 10; i++) begin
      irq <= (i < 3) ? 7'(116 + i) : 7'($urandom_range(117));
      alt <= 1'($urandom);
      trap <= 3'($urandom_range(4));
      @(posedge clk);
      rd(ADDR_VECTOR, irq > 117 ? 32'h200 :
         32'h14 + 32'(irq) * 2 + (alt ? 32'h100 : 0));
    end
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
